//--- core/sram_host_ctrl.sv
// host-side cycle sequencer for an asynchronous 16-bit static ram
module sram_host_ctrl #(
  parameter int ADDR_W = sram_timing_pkg::ADDR_W,
  parameter int DATA_W = sram_timing_pkg::DATA_W
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              fast_grade,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [1:0]        req_lane_en,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  input  wire logic              retention_req,
  output logic                   retention_ready,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   primary_select_n,
  output logic                   secondary_select,
  output logic                   write_strobe_n,
  output logic                   drive_enable_n,
  output logic                   low_lane_n,
  output logic                   high_lane_n,
  input  wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0]      data_out,
  output logic [1:0]             data_oe
);

  localparam int CW = sram_timing_pkg::CNT_W;

  // ==========================================================
  // state
  typedef struct packed {
    sram_timing_pkg::ctrl_state_e state;
    logic [ADDR_W-1:0]            addr;
    logic [DATA_W-1:0]            wdata;
    logic [1:0]                   lanes;
    logic                         selected;
    logic                         we_n;
    logic                         de_n;
    logic [1:0]                   drive;
    logic                         rsp;
    logic                         ret_ready;
  } ctrl_s;

  ctrl_s s;
  ctrl_s n;

  logic          phase_load;
  logic [CW-1:0] phase_value;
  logic          phase_done;
  logic          bus_load;
  logic          bus_free;
  logic          capture;

  logic [CW-1:0] cycle_cyc;
  logic [CW-1:0] pulse_cyc;
  logic [CW-1:0] recover_cyc;

  // ==========================================================
  // helpers
  // done is high while the count is zero and is acted on one edge later, so an interval of c cycles loads c-1
  function automatic logic [CW-1:0] load_for(input logic [CW-1:0] cycles);
    return cycles - CW'(1);
  endfunction

  // a lane pin is low only while the memory is selected
  function automatic logic lane_pin_n(input logic selected, input logic enabled);
    return !(selected && enabled);
  endfunction

  // strobe, selects and lane drive fall on one edge
  function automatic ctrl_s start_write(input ctrl_s cur);
    ctrl_s nxt;
    nxt          = cur;
    nxt.state    = sram_timing_pkg::ST_W_PULSE;
    nxt.selected = 1'b1;
    nxt.we_n     = 1'b0;
    nxt.drive    = cur.lanes;
    return nxt;
  endfunction

  // ==========================================================
  // grade-dependent counts
  assign cycle_cyc = sram_timing_pkg::grade_count(fast_grade,
                                                  sram_timing_pkg::FAST_CYCLE_CYC,
                                                  sram_timing_pkg::SLOW_CYCLE_CYC);
  assign pulse_cyc = sram_timing_pkg::grade_count(fast_grade,
                                                  sram_timing_pkg::FAST_PULSE_CYC,
                                                  sram_timing_pkg::SLOW_PULSE_CYC);
  // recovery fills the rest of the write cycle after the strobe rises
  assign recover_cyc = cycle_cyc - pulse_cyc;

  // ==========================================================
  // timers
  interval_timer #(
    .WIDTH      (CW)
  ) phase_timer (
    .clock      (clock),
    .rst        (rst),
    .load       (phase_load),
    .load_value (phase_value),
    .done       (phase_done)
  );

  // counts out the memory's release of the bus after a read
  interval_timer #(
    .WIDTH      (CW)
  ) bus_timer (
    .clock      (clock),
    .rst        (rst),
    .load       (bus_load),
    .load_value (load_for(sram_timing_pkg::FLOAT_CYC)),
    .done       (bus_free)
  );

  // ==========================================================
  // sequencer
  assign req_ready = (s.state == sram_timing_pkg::ST_IDLE) && !retention_req;

  always_comb begin
    n           = s;
    n.rsp       = 1'b0;
    phase_load  = 1'b0;
    phase_value = '0;
    bus_load    = 1'b0;
    capture     = 1'b0;
    case (s.state)
      sram_timing_pkg::ST_IDLE: begin
        if (retention_req) begin
          // already deselected in idle, so supply may drop at once
          n.state     = sram_timing_pkg::ST_RET_HOLD;
          n.ret_ready = 1'b1;
        end else if (req_valid) begin
          n.addr  = req_addr;
          n.lanes = req_lane_en;
          n.wdata = req_wdata;
          if (req_write) begin
            if (req_lane_en == 2'h0) begin
              // no lane to write, so the memory is never strobed
              n.state = sram_timing_pkg::ST_IDLE;
            end else if (!bus_free) begin
              // read data may still be on the pins
              n.state = sram_timing_pkg::ST_TURN;
            end else begin
              n           = start_write(n);
              phase_load  = 1'b1;
              phase_value = load_for(pulse_cyc);
            end
          end else begin
            // address, selects and lanes all move on the same edge
            n.state     = sram_timing_pkg::ST_R_ACCESS;
            n.selected  = 1'b1;
            n.de_n      = 1'b0;
            n.we_n      = 1'b1;
            phase_load  = 1'b1;
            phase_value = load_for(cycle_cyc);
          end
        end
      end
      sram_timing_pkg::ST_TURN: begin
        if (bus_free) begin
          // float wait has run, so lane drive cannot meet read data
          n           = start_write(n);
          phase_load  = 1'b1;
          phase_value = load_for(pulse_cyc);
        end
      end
      sram_timing_pkg::ST_W_PULSE: begin
        // drive-enable stays high, so no float wait on the strobe
        n.de_n = 1'b1;
        if (phase_done) begin
          // strobe rise ends the write; data, address and lanes held past it
          n.state     = sram_timing_pkg::ST_W_RECOVER;
          n.we_n      = 1'b1;
          phase_load  = 1'b1;
          phase_value = load_for(recover_cyc);
        end
      end
      sram_timing_pkg::ST_W_RECOVER: begin
        if (phase_done) begin
          n.state    = sram_timing_pkg::ST_IDLE;
          n.selected = 1'b0;
          n.drive    = 2'h0;
        end
      end
      sram_timing_pkg::ST_R_ACCESS: begin
        if (phase_done) begin
          n.state    = sram_timing_pkg::ST_IDLE;
          capture    = 1'b1;
          n.rsp      = 1'b1;
          n.selected = 1'b0;
          n.de_n     = 1'b1;
          bus_load   = 1'b1;
        end
      end
      sram_timing_pkg::ST_RET_HOLD: begin
        if (!retention_req) begin
          // supply is back; one full read cycle before any access
          n.state     = sram_timing_pkg::ST_RET_RECOVER;
          n.ret_ready = 1'b0;
          phase_load  = 1'b1;
          phase_value = load_for(cycle_cyc);
        end
      end
      sram_timing_pkg::ST_RET_RECOVER: begin
        if (phase_done) begin
          n.state = sram_timing_pkg::ST_IDLE;
        end
      end
      default: begin
        n.state     = sram_timing_pkg::ST_IDLE;
        n.selected  = 1'b0;
        n.we_n      = 1'b1;
        n.de_n      = 1'b1;
        n.drive     = 2'h0;
        n.ret_ready = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s           <= '0;
      s.state     <= sram_timing_pkg::ST_IDLE;
      s.we_n      <= 1'b1;
      s.de_n      <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // data pins
  data_lane_io #(
    .DATA_W        (DATA_W)
  ) lane_io (
    .clock         (clock),
    .rst           (rst),
    .next_drive    (n.drive),
    .wdata         (n.wdata),
    .capture       (capture),
    .capture_lanes (s.lanes),
    .data_in       (data_in),
    .data_out      (data_out),
    .data_oe       (data_oe),
    .rdata         (rsp_rdata)
  );

  // ==========================================================
  // control pins from flip-flops; the lane pins gate the lane flops with the select flop
  // lanes only go low while selected, so idle is deselected on every path
  assign mem_addr         = s.addr;
  assign primary_select_n = !s.selected;
  assign secondary_select = s.selected;
  assign write_strobe_n   = s.we_n;
  assign drive_enable_n   = s.de_n;
  assign low_lane_n       = lane_pin_n(s.selected, s.lanes[0]);
  assign high_lane_n      = lane_pin_n(s.selected, s.lanes[1]);
  assign rsp_valid        = s.rsp;
  assign retention_ready  = s.ret_ready;

endmodule

//--- inc/sram_timing_pkg.sv
// constants, timing counts and state encoding for the async sram host controller
package sram_timing_pkg;

  // ==========================================================
  // widths and clock
  localparam int ADDR_W          = 20;
  localparam int DATA_W          = 16;
  localparam int CNT_W           = 5;
  localparam int CLOCK_PERIOD_PS = 4000;

  // ==========================================================
  // times in ns, fast grade then slow grade
  localparam int FAST_CYCLE_NS     = 45;
  localparam int SLOW_CYCLE_NS     = 55;
  localparam int FAST_WRITE_END_NS = 35;
  localparam int SLOW_WRITE_END_NS = 40;
  localparam int DATA_SETUP_NS     = 28;
  localparam int DATA_HOLD_NS      = 0;
  localparam int FLOAT_NS          = 18;
  localparam int RETENTION_SETUP_NS = 0;

  // ==========================================================
  // least times round up, never below one cycle
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max_int(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // strobe pulse covers select, lane and address setup as well as data setup
  localparam logic [CNT_W-1:0] FAST_CYCLE_CYC =
    CNT_W'(ns_to_cycles(FAST_CYCLE_NS));
  localparam logic [CNT_W-1:0] SLOW_CYCLE_CYC =
    CNT_W'(ns_to_cycles(SLOW_CYCLE_NS));
  localparam logic [CNT_W-1:0] FAST_PULSE_CYC =
    CNT_W'(max_int(ns_to_cycles(FAST_WRITE_END_NS), ns_to_cycles(DATA_SETUP_NS)));
  localparam logic [CNT_W-1:0] SLOW_PULSE_CYC =
    CNT_W'(max_int(ns_to_cycles(SLOW_WRITE_END_NS), ns_to_cycles(DATA_SETUP_NS)));
  localparam logic [CNT_W-1:0] FLOAT_CYC =
    CNT_W'(ns_to_cycles(FLOAT_NS));

  // ==========================================================
  // grade selection, used for the cycle and pulse counts; the float wait is the same in both grades
  function automatic logic [CNT_W-1:0] grade_count(input logic fast,
                                                   input logic [CNT_W-1:0] fast_v,
                                                   input logic [CNT_W-1:0] slow_v);
    return fast ? fast_v : slow_v;
  endfunction

  // ==========================================================
  // controller states, gray along the idle-turn-write and idle-read paths
  typedef enum logic [2:0] {
    ST_IDLE        = 3'h0,
    ST_TURN        = 3'h1,
    ST_W_PULSE     = 3'h3,
    ST_W_RECOVER   = 3'h2,
    ST_R_ACCESS    = 3'h4,
    ST_RET_HOLD    = 3'h7,
    ST_RET_RECOVER = 3'h5
  } ctrl_state_e;

endpackage

//--- core/interval_timer.sv
// down-counter that marks the end of a timed interval
module interval_timer #(
  parameter int WIDTH = sram_timing_pkg::CNT_W
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic                  done
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } timer_s;

  timer_s state;
  timer_s next_state;

  // ==========================================================
  // count
  always_comb begin
    next_state = state;
    if (load) begin
      next_state.count = load_value;
    end else if (state.count != '0) begin
      next_state.count = state.count - WIDTH'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign done = (state.count == '0);

endmodule

//--- core/data_lane_io.sv
// registered data pin drive and per-lane read capture
module data_lane_io #(
  parameter int DATA_W = sram_timing_pkg::DATA_W
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [1:0]        next_drive,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              capture,
  input  wire logic [1:0]        capture_lanes,
  input  wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0]      data_out,
  output logic [1:0]             data_oe,
  output logic [DATA_W-1:0]      rdata
);

  localparam int HALF = DATA_W / 2;

  typedef struct packed {
    logic [DATA_W-1:0] dout;
    logic [1:0]        oe;
    logic [DATA_W-1:0] rd;
  } io_s;

  io_s state;
  io_s next_state;

  // ==========================================================
  // lanes: bit 0 is the low byte, bit 1 the high byte
  always_comb begin
    next_state     = state;
    next_state.oe  = next_drive;
    if (next_drive != 2'h0) begin
      next_state.dout = wdata;
    end
    if (capture) begin
      // unselected lane reads as zero since the memory leaves it floating
      next_state.rd[HALF-1:0]      = capture_lanes[0] ? data_in[HALF-1:0] : '0;
      next_state.rd[DATA_W-1:HALF] = capture_lanes[1] ? data_in[DATA_W-1:HALF] : '0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign data_out = state.dout;
  assign data_oe  = state.oe;
  assign rdata    = state.rd;

endmodule

//--- tb/sram_host_ctrl_props.sv
// pin timing checker for the async sram host controller
module sram_host_ctrl_props (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        fast_grade,
  input  wire logic        rsp_valid,
  input  wire logic        retention_ready,
  input  wire logic [19:0] mem_addr,
  input  wire logic        primary_select_n,
  input  wire logic        secondary_select,
  input  wire logic        write_strobe_n,
  input  wire logic        drive_enable_n,
  input  wire logic        low_lane_n,
  input  wire logic        high_lane_n,
  input  wire logic [15:0] data_out,
  input  wire logic [1:0]  data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================================
  // strobe and drive
  property p_strobe_read; !drive_enable_n |-> write_strobe_n; endproperty
  a_strobe_read: assert property (p_strobe_read) else $error("strobe low in read");
  property p_drive_off; !write_strobe_n |-> drive_enable_n; endproperty
  a_drive_off: assert property (p_drive_off) else $error("drive on in write");
  property p_write_qual;
    !write_strobe_n |-> !primary_select_n && secondary_select && !(low_lane_n && high_lane_n);
  endproperty
  a_write_qual: assert property (p_write_qual) else $error("write unqualified");
  property p_pulse; $fell(write_strobe_n) |-> (!write_strobe_n)[*8] ##1 !write_strobe_n; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe pulse short");
  property p_pulse_slow; $fell(write_strobe_n) && !fast_grade |-> ##9 !write_strobe_n; endproperty
  a_pulse_slow: assert property (p_pulse_slow) else $error("slow pulse short");
  // ==========================================================
  // address and data
  property p_addr; !primary_select_n && $past(!primary_select_n) |-> $stable(mem_addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_lanes; !write_strobe_n |-> data_oe == {!high_lane_n, !low_lane_n}; endproperty
  a_lanes: assert property (p_lanes) else $error("lane drive wrong");
  property p_data; $past(!write_strobe_n) |-> $stable(data_out) && $stable(data_oe); endproperty
  a_data: assert property (p_data) else $error("write data moved");
  property p_turn; $rose(drive_enable_n) |-> (data_oe == 2'h0)[*5]; endproperty
  a_turn: assert property (p_turn) else $error("drive before float");
  property p_read;
    $fell(drive_enable_n) |-> if (fast_grade) ##12 rsp_valid else ##14 rsp_valid;
  endproperty
  a_read: assert property (p_read) else $error("read answer late");
  // ==========================================================
  // retention
  property p_ret; retention_ready |-> primary_select_n && !secondary_select; endproperty
  a_ret: assert property (p_ret) else $error("selected in retention");
  property p_recover;
    $fell(retention_ready) |-> primary_select_n[*8] ##1 primary_select_n[*4];
  endproperty
  a_recover: assert property (p_recover) else $error("access too soon");
  c_write: cover property ($rose(write_strobe_n));
  c_read: cover property (rsp_valid);
  c_ret: cover property ($fell(retention_ready));
endmodule

bind sram_host_ctrl sram_host_ctrl_props i_sram_host_ctrl_props (.*);

//--- tb/sram_model.sv
// behavioural 1M x 16 async static ram seen from its pins
module sram_model (
  input  wire logic        clock,
  input  wire logic        fast_grade,
  input  wire logic [19:0] mem_addr,
  input  wire logic        primary_select_n,
  input  wire logic        secondary_select,
  input  wire logic        write_strobe_n,
  input  wire logic        drive_enable_n,
  input  wire logic        low_lane_n,
  input  wire logic        high_lane_n,
  input  wire logic [15:0] data_out,
  input  wire logic [1:0]  data_oe,
  output logic [15:0]      data_in,
  output logic             clash
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [logic [19:0]];
  logic [15:0] junk = 16'h5A3C;
  logic [15:0] rd = 16'h0000;
  logic [15:0] w;
  logic [4:0]  cnt = 5'h00;
  logic [4:0]  hold = 5'h00;
  logic        valid = 1'b0;
  logic        sel;
  logic        rdmode;
  // ==========================================================
  // floating pins toggle so a stale value never reads back
  assign sel = !primary_select_n && secondary_select && !(low_lane_n && high_lane_n);
  assign rdmode = sel && write_strobe_n && !drive_enable_n;
  assign data_in[7:0] = data_oe[0] ? data_out[7:0] : (valid && !low_lane_n ? rd[7:0] : junk[7:0]);
  assign data_in[15:8] = data_oe[1] ? data_out[15:8] : (valid && !high_lane_n ? rd[15:8] : junk[15:8]);
  assign clash = |data_oe && (rdmode || hold != 5'h00);
  always @(posedge clock) begin
    junk <= ~junk;
    cnt <= rdmode ? cnt + 5'h01 : 5'h00;
    // valid only once the grade's access time has run since select
    valid <= rdmode && (int'(cnt) + 2) * 4 >= (fast_grade ? 45 : 55);
    rd <= mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
    hold <= rdmode ? 5'h05 : (hold != 5'h00 ? hold - 5'h01 : 5'h00);
    if (!write_strobe_n && sel) begin
      w = mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
      if (!low_lane_n) w[7:0] = data_in[7:0];
      if (!high_lane_n) w[15:8] = data_in[15:8];
      mem[mem_addr] = w;
    end
  end
endmodule

//--- tb/async_sram_cycle_timing_test.sv
// self-checking bench for the async sram host controller
module async_sram_cycle_timing_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // pins and bookkeeping
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        fast_grade = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [19:0] req_addr = 20'h00000;
  logic [15:0] req_wdata = 16'h0000;
  logic [1:0]  req_lane_en = 2'h0;
  logic        retention_req = 1'b0;
  logic        req_ready;
  logic        rsp_valid;
  logic [15:0] rsp_rdata;
  logic        retention_ready;
  logic [19:0] mem_addr;
  logic        primary_select_n;
  logic        secondary_select;
  logic        write_strobe_n;
  logic        drive_enable_n;
  logic        low_lane_n;
  logic        high_lane_n;
  logic [15:0] data_in;
  logic [15:0] data_out;
  logic [1:0]  data_oe;
  logic        clash;
  logic [15:0] shadow [logic [19:0]];
  logic [15:0] expq [$];
  int          bad_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  integer      seed = 32'hA3655464;

  sram_host_ctrl i_sram_host_ctrl (.*);
  sram_model i_sram_model (.*);

  initial forever #2 clock = ~clock;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wait_idle();
    do @(negedge clock); while (req_ready !== 1'b1);
  endtask

  // expectation noted when the request is issued
  task automatic req(input logic w, input logic [19:0] a, input logic [15:0] d,
                     input logic [1:0] ln);
    logic [15:0] m;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    if (w) shadow[a] = ((shadow.exists(a) ? shadow[a] : 16'h0000) & ~m) | (d & m);
    else expq.push_back((shadow.exists(a) ? shadow[a] : 16'h0000) & m);
    wait_idle();
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_lane_en <= ln;
    @(posedge clock);
    req_valid <= 1'b0;
  endtask

  // ==========================================================
  // watchers
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      report_and_stop();
    end
  end

  always @(posedge clock) begin
    if (clash === 1'b1) chk("bus_clash", 32'h0, 32'h1);
    if (primary_select_n === 1'b0) begin
      chk("mem_addr", {12'h000, req_addr}, {12'h000, mem_addr});
    end
    if (rsp_valid === 1'b1) begin
      if (expq.size() == 0) chk("rsp_extra", 32'h0, 32'h1);
      else chk("rsp_rdata", {16'h0000, expq.pop_front()}, {16'h0000, rsp_rdata});
    end
  end

  // ==========================================================
  // scenarios
  initial begin
    logic [31:0] r;
    logic [19:0] a;
    logic [15:0] d;
    logic [1:0]  ln;
    int          n;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk("idle_pins", 32'h178, {primary_select_n, secondary_select, write_strobe_n,
        drive_enable_n, low_lane_n, high_lane_n, data_oe, rsp_valid});
    $display("test reset done");
    for (int g = 1; g >= 0; g--) begin
      wait_idle();
      @(posedge clock);
      fast_grade <= g[0];
      for (int i = 0; i < 6; i++) begin
        r = $random(seed);
        a = r[19:0];
        r = $random(seed);
        d = r[15:0];
        ln = 2'(i % 3 + 1);
        req(1'b1, a, ~d, 2'h3);
        req(1'b1, a, d, ln);
        req(1'b0, a, 16'h0000, 2'h3);
        req(1'b0, a, 16'h0000, ln);
      end
      $display("test grade %0d done", g);
    end
    req(1'b1, a, ~d, 2'h0);
    req(1'b0, a, 16'h0000, 2'h0);
    $display("test no-lane done");
    wait_idle();
    @(posedge clock);
    retention_req <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    chk("retention", 32'h5, {29'h0, retention_ready, req_ready, primary_select_n});
    @(posedge clock);
    retention_req <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    chk("recovery_ok", 32'h1,
        {31'h0, n > int'(sram_timing_pkg::SLOW_CYCLE_CYC) && n < 100});
    req(1'b0, a, 16'h0000, 2'h3);
    $display("test retention done");
    repeat (30) @(posedge clock);
    chk("pending_reads", 32'h0, expq.size());
    report_and_stop();
  end
endmodule
